// [hdl/dbg_serial_pkg.sv]
// Constants for the debug serial link with autobaud
package dbg_serial_pkg;
    localparam int DATA_BITS = 8;
    localparam int AUTOBAUD_LOW_BITS = 8;
    localparam int MIN_BAUD_DIV = 512;
    localparam int MAX_BAUD_DIV = 4;
    localparam int AUTOBAUD_SHIFT = 3;
    localparam int BIT_CNT_W = 4;
    localparam int CLK_PERIOD_NS = 8;
    localparam int PERIOD_W = 10;
    localparam int LOW_CNT_W = 13;
    localparam logic [7:0] AUTOBAUD_CHAR = 8'h80;
    localparam logic LINE_IDLE = 1'b1;
    localparam logic START_LEVEL = 1'b0;
    localparam logic STOP_LEVEL = 1'b1;
endpackage : dbg_serial_pkg

// [hdl/baud_tick_if.sv]
// Bit timing signals shared between the link and its bit timer
`timescale 1ns/1ps
interface baud_tick_if #(parameter int PW = 10);
    logic restart;
    logic [PW-1:0] period;
    logic half_tick;
    logic full_tick;
    modport timer (input restart, input period,
        output half_tick, output full_tick);
    modport user (output restart, output period,
        input half_tick, input full_tick);
endinterface : baud_tick_if

// [hdl/baud_timer.sv]
// Bit period timer producing mid-bit and end-of-bit ticks
`timescale 1ns/1ps
module baud_timer #(
    parameter int PW = 10
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    baud_tick_if.timer bt
);
    logic [PW-1:0] cnt;
    wire logic [PW-1:0] half_point;
    wire logic at_end;
    assign half_point = bt.period >> 1;
    assign at_end = (cnt == bt.period - PW'(1));
    assign bt.half_tick = !bt.restart && (cnt == half_point);
    assign bt.full_tick = !bt.restart && at_end;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= '0;
        end else if (bt.restart || at_end) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + PW'(1);
        end
    end
endmodule : baud_timer

// [hdl/debug_serial_unit.sv]
// Debug serial character link with autobaud detection
`timescale 1ns/1ps
module debug_serial_unit
    import dbg_serial_pkg::*;
#(
    parameter int PW = PERIOD_W
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic rx_line_i,
    output logic tx_line_o,
    output logic baud_locked_o,
    output logic [PW-1:0] bit_period_o,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    output logic rx_frame_err_o,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o
);
    import dbg_serial_pkg::*;

    // ==========================================================
    // Types and state
    typedef enum logic [2:0] {
        AB_WAIT_IDLE = 3'b000,
        AB_WAIT_LOW = 3'b001,
        AB_MEASURE = 3'b011,
        AB_WAIT_END = 3'b010,
        AB_LOCKED = 3'b110
    } ab_state_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_START = 2'b01,
        RX_DATA = 2'b11,
        RX_STOP = 2'b10
    } rx_state_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_START = 2'b01,
        TX_DATA = 2'b11,
        TX_STOP = 2'b10
    } tx_state_t;

    ab_state_t ab_state;
    ab_state_t next_ab_state;
    rx_state_t rx_state;
    tx_state_t tx_state;
    logic [LOW_CNT_W-1:0] low_cnt;
    logic [BIT_CNT_W-1:0] rx_bits;
    logic [BIT_CNT_W-1:0] tx_bits;
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    logic rx_prev;

    baud_tick_if #(.PW(PW)) rx_bt ();
    baud_tick_if #(.PW(PW)) tx_bt ();

    // ==========================================================
    // Autobaud detector
    wire logic locked;
    wire logic line_fell;
    wire logic [LOW_CNT_W-1:0] low_cnt_max;
    assign locked = (ab_state == AB_LOCKED);
    assign line_fell = rx_prev && (rx_line_i == START_LEVEL);
    assign low_cnt_max = LOW_CNT_W'(MIN_BAUD_DIV * AUTOBAUD_LOW_BITS);

    always_comb begin
        next_ab_state = ab_state;
        case (ab_state)
            AB_WAIT_IDLE: begin
                if (rx_line_i == LINE_IDLE) next_ab_state = AB_WAIT_LOW;
            end
            AB_WAIT_LOW: if (line_fell) next_ab_state = AB_MEASURE;
            AB_MEASURE: begin
                if (rx_line_i == LINE_IDLE) begin
                    next_ab_state = AB_WAIT_END;
                end else if (low_cnt == low_cnt_max) begin
                    next_ab_state = AB_WAIT_IDLE;
                end
            end
            AB_WAIT_END: next_ab_state = AB_LOCKED;
            AB_LOCKED: next_ab_state = AB_LOCKED;
            default: next_ab_state = AB_WAIT_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ab_state <= AB_WAIT_IDLE;
            low_cnt <= '0;
            rx_prev <= LINE_IDLE;
            bit_period_o <= '0;
        end else begin
            ab_state <= next_ab_state;
            rx_prev <= rx_line_i;
            if (ab_state == AB_MEASURE) begin
                low_cnt <= low_cnt + LOW_CNT_W'(1);
            end else begin
                low_cnt <= LOW_CNT_W'(1);
            end
            if (ab_state == AB_WAIT_END) begin
                bit_period_o <= PW'(low_cnt >> AUTOBAUD_SHIFT);
            end
        end
    end

    assign baud_locked_o = locked;

    // ==========================================================
    // Receiver, sampling at mid-bit with the measured period
    assign rx_bt.period = bit_period_o;
    assign rx_bt.restart = (rx_state == RX_IDLE);
    baud_timer #(.PW(PW)) u_rx_timer (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .bt(rx_bt.timer)
    );

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_state <= RX_IDLE;
            rx_bits <= '0;
            rx_shift <= '0;
            rx_data_o <= '0;
            rx_valid_o <= 1'b0;
            rx_frame_err_o <= 1'b0;
        end else begin
            rx_valid_o <= 1'b0;
            case (rx_state)
                RX_IDLE: if (locked && line_fell) rx_state <= RX_START;
                RX_START: begin
                    if (rx_bt.half_tick) begin
                        rx_state <= (rx_line_i == START_LEVEL) ? RX_DATA
                                                               : RX_IDLE;
                        rx_bits <= '0;
                    end
                end
                RX_DATA: begin
                    if (rx_bt.half_tick) begin
                        rx_shift <= {rx_line_i, rx_shift[7:1]};
                        rx_bits <= rx_bits + BIT_CNT_W'(1);
                        if (rx_bits == BIT_CNT_W'(DATA_BITS - 1)) begin
                            rx_state <= RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_bt.half_tick) begin
                        rx_data_o <= rx_shift;
                        rx_valid_o <= 1'b1;
                        rx_frame_err_o <= (rx_line_i != STOP_LEVEL);
                        rx_state <= RX_IDLE;
                    end
                end
                default: rx_state <= RX_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Transmitter, silent until the bit period is locked
    assign tx_bt.period = bit_period_o;
    assign tx_bt.restart = (tx_state == TX_IDLE);
    assign tx_ready_o = locked && (tx_state == TX_IDLE);
    baud_timer #(.PW(PW)) u_tx_timer (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .bt(tx_bt.timer)
    );

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_state <= TX_IDLE;
            tx_line_o <= LINE_IDLE;
            tx_bits <= '0;
            tx_shift <= '0;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    tx_line_o <= LINE_IDLE;
                    if (tx_valid_i && tx_ready_o) begin
                        tx_shift <= tx_data_i;
                        tx_line_o <= START_LEVEL;
                        tx_state <= TX_START;
                    end
                end
                TX_START: begin
                    if (tx_bt.full_tick) begin
                        tx_line_o <= tx_shift[0];
                        tx_shift <= tx_shift >> 1;
                        tx_bits <= '0;
                        tx_state <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_bt.full_tick) begin
                        tx_bits <= tx_bits + BIT_CNT_W'(1);
                        if (tx_bits == BIT_CNT_W'(DATA_BITS - 1)) begin
                            tx_line_o <= STOP_LEVEL;
                            tx_state <= TX_STOP;
                        end else begin
                            tx_line_o <= tx_shift[0];
                            tx_shift <= tx_shift >> 1;
                        end
                    end
                end
                TX_STOP: begin
                    if (tx_bt.full_tick) begin
                        tx_state <= TX_IDLE;
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Assertions
    property p_idle_tx;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !locked |-> (tx_line_o == LINE_IDLE && !tx_ready_o);
    endproperty
    a_idle_tx: assert property (p_idle_tx)
        else $error("tx active before lock");

    property p_no_rx_before_lock;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !locked |-> !rx_valid_o;
    endproperty
    a_no_rx_before_lock: assert property (p_no_rx_before_lock)
        else $error("rx data before lock");

    property p_lock_period;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (ab_state == AB_WAIT_END) |=>
            (locked && bit_period_o == PW'($past(low_cnt) >> AUTOBAUD_SHIFT));
    endproperty
    a_lock_period: assert property (p_lock_period)
        else $error("period not low time over eight");

    property p_lock_stays;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        locked |=> locked && $stable(bit_period_o);
    endproperty
    a_lock_stays: assert property (p_lock_stays)
        else $error("lock lost");

    property p_start_bit;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (tx_valid_i && tx_ready_o) |=> (tx_line_o == START_LEVEL);
    endproperty
    a_start_bit: assert property (p_start_bit)
        else $error("missing start bit");

    property p_stop_bit;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (tx_state == TX_STOP) |-> (tx_line_o == STOP_LEVEL);
    endproperty
    a_stop_bit: assert property (p_stop_bit)
        else $error("stop bit not high");

    property p_measure_bound;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (ab_state == AB_MEASURE) |-> (low_cnt <= low_cnt_max);
    endproperty
    a_measure_bound: assert property (p_measure_bound)
        else $error("low count overran");

    property p_ready_drop;
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (tx_valid_i && tx_ready_o) |=> !tx_ready_o [*2];
    endproperty
    a_ready_drop: assert property (p_ready_drop)
        else $error("ready during frame");

    c_lock: cover property (@(posedge ref_clk_i) $rose(locked));
    c_rx: cover property (@(posedge ref_clk_i) rx_valid_o);
    c_tx: cover property (@(posedge ref_clk_i) tx_state == TX_STOP);
endmodule : debug_serial_unit

// [sim/host_link_model.sv]
// Host debugger model: sends framed characters and decodes replies
`timescale 1ns/1ps
module host_link_model (
    input wire logic ref_clk_i,
    input wire logic line_i,
    output logic line_o
);
    // ==========================================
    // Bit period in clocks, kept at 8 or longer
    int bit_p = 16;
    logic [7:0] rx_sh;
    logic [7:0] got_q[$];

    initial line_o = 1'b1;

    // ==========================================
    // Sending one character
    task automatic send_char(input logic [7:0] b, input logic stop);
        logic [9:0] frame;
        frame = {stop, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge ref_clk_i);
            line_o = frame[i];
            repeat (bit_p - 1) @(negedge ref_clk_i);
        end
        @(negedge ref_clk_i);
        line_o = 1'b1;
        repeat (bit_p / 2) @(negedge ref_clk_i);
    endtask

    // ==========================================
    // Decoding the device's line at mid-bit
    always begin
        @(posedge ref_clk_i);
        if (line_i === 1'b0) begin
            repeat (bit_p / 2) @(posedge ref_clk_i);
            for (int i = 0; i < 8; i++) begin
                repeat (bit_p) @(posedge ref_clk_i);
                rx_sh[i] = line_i;
            end
            repeat (bit_p) @(posedge ref_clk_i);
            got_q.push_back(rx_sh);
        end
    end
endmodule // host_link_model

// [sim/test_debug_serial_unit.sv]
// Self-checking testbench for the debug serial unit
`timescale 1ns/1ps
module test_debug_serial_unit;
    import dbg_serial_pkg::*;
    logic ref_clk_i;
    logic rst_n_i;
    logic rx_line_i;
    logic tx_line_o;
    logic baud_locked_o;
    logic [9:0] bit_period_o;
    logic [7:0] rx_data_o;
    logic rx_valid_o;
    logic rx_frame_err_o;
    logic [7:0] tx_data_i;
    logic tx_valid_i;
    logic tx_ready_o;
    int mismatches = 0;
    int tests_run = 0;
    int rx_seen = 0;
    logic [7:0] rx_last;
    logic rx_err_last;

    debug_serial_unit dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .rx_line_i(rx_line_i), .tx_line_o(tx_line_o),
        .baud_locked_o(baud_locked_o), .bit_period_o(bit_period_o),
        .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o),
        .rx_frame_err_o(rx_frame_err_o), .tx_data_i(tx_data_i),
        .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o));
    host_link_model host (.ref_clk_i(ref_clk_i), .line_i(tx_line_o),
        .line_o(rx_line_i));

    // ==========================================
    // Received byte monitor
    always @(posedge ref_clk_i) begin
        if (rx_valid_o === 1'b1) begin
            rx_seen++;
            rx_last = rx_data_o;
            rx_err_last = rx_frame_err_o;
        end
    end

    // ==========================================
    // Shared tasks
    task automatic bad(input string msg);
        mismatches++;
        $display("BAD %0t %s", $time, msg);
    endtask

    task automatic do_reset();
        @(negedge ref_clk_i);
        rst_n_i = 1'b0;
        repeat (4) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
    endtask

    task automatic send_tx(input logic [7:0] b);
        int w;
        w = 0;
        @(negedge ref_clk_i);
        tx_data_i = b;
        tx_valid_i = 1'b1;
        // Ready is settled at the falling edge; next rising edge accepts
        while (tx_ready_o !== 1'b1 && w < 20000) begin
            @(negedge ref_clk_i);
            w++;
        end
        @(negedge ref_clk_i);
        tx_valid_i = 1'b0;
        tests_run++;
        if (w >= 20000) bad("tx never ready");
        else if (tx_line_o !== START_LEVEL) bad("no start bit");
    endtask

    // ==========================================
    // Scenarios
    task automatic t_idle();
        repeat (200) begin
            @(negedge ref_clk_i);
            tests_run++;
            if (tx_line_o !== 1'b1 || tx_ready_o !== 1'b0) bad("not idle");
        end
        tests_run++;
        if (baud_locked_o !== 1'b0 || rx_seen != 0) bad("acted");
        $display("t_idle done");
    endtask

    task automatic t_rate(input int p);
        logic [9:0] exp;
        int n0;
        exp = p[9:0];
        do_reset();
        tests_run++;
        if (baud_locked_o !== 1'b0) bad("lock kept over reset");
        host.bit_p = p;
        repeat (p) @(negedge ref_clk_i);
        host.send_char(AUTOBAUD_CHAR, 1'b1);
        tests_run++;
        if (baud_locked_o !== 1'b1) bad("no lock");
        tests_run++;
        if (bit_period_o !== exp) bad("bit period");
        n0 = rx_seen;
        host.send_char(8'h5a, 1'b1);
        tests_run++;
        if (rx_seen != n0 + 1 || rx_last !== 8'h5a) bad("rx byte");
        host.got_q.delete();
        send_tx(8'h96);
        send_tx(8'h01);
        repeat (12 * p) @(negedge ref_clk_i);
        tests_run++;
        if (host.got_q.size() != 2) bad("tx count");
        else if (host.got_q[0] !== 8'h96 || host.got_q[1] !== 8'h01) begin
            bad("tx data");
        end
        $display("t_rate %0d done", p);
    endtask

    task automatic t_frame();
        int n0;
        n0 = rx_seen;
        host.send_char(8'hc3, 1'b0);
        tests_run++;
        if (rx_seen != n0 + 1 || rx_err_last !== 1'b1) bad("frame err");
        tests_run++;
        if (rx_last !== 8'hc3) bad("byte lost");
        host.send_char(8'h80, 1'b1);
        tests_run++;
        if (rx_last !== 8'h80 || rx_err_last !== 1'b0) bad("data 80");
        tests_run++;
        if (bit_period_o !== 10'h010) bad("period moved");
        $display("t_frame done");
    endtask

    task automatic t_overrun();
        do_reset();
        // Low run of 8 x 520 clocks exceeds the measurable limit
        host.bit_p = 520;
        repeat (16) @(negedge ref_clk_i);
        host.send_char(AUTOBAUD_CHAR, 1'b1);
        tests_run++;
        if (baud_locked_o !== 1'b0) bad("locked on long low");
        host.bit_p = 16;
        host.send_char(AUTOBAUD_CHAR, 1'b1);
        tests_run++;
        if (baud_locked_o !== 1'b1 || bit_period_o !== 10'h010) begin
            bad("no relock after long low");
        end
        $display("t_overrun done");
    endtask

    task automatic conclude();
        $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ==========================================
    // Clock, sequence and watchdog
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    initial begin
        rst_n_i = 1'b0;
        tx_data_i = 8'h00;
        tx_valid_i = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        t_idle();
        tx_valid_i = 1'b0;
        t_rate(16);
        t_frame();
        t_overrun();
        t_rate(8);
        t_rate(504);
        conclude();
    end

    initial begin
        repeat (60000) @(posedge ref_clk_i);
        bad("watchdog");
        conclude();
    end
endmodule // test_debug_serial_unit
